// ---- rtl/sscx_pkg.sv ----
// Constants and types shared by the synchronous serial channel
package sscx_pkg;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 3;
   localparam logic [3:0]  FRAME_BITS   = 4'h8;
   localparam logic [3:0]  OVR_BIT_IDX  = 4'h6;
   // ==========================================================
   // Register offsets
   localparam logic [2:0]  ADDR_DATA    = 3'h0;
   localparam logic [2:0]  ADDR_STATUS  = 3'h1;
   localparam logic [2:0]  ADDR_BAUD    = 3'h2;
   localparam logic [2:0]  ADDR_MODE    = 3'h3;
   localparam logic [2:0]  ADDR_CTRL0   = 3'h4;
   localparam logic [2:0]  ADDR_CTRL1   = 3'h5;
   localparam logic [2:0]  ADDR_COMMON  = 3'h6;
   // ==========================================================
   // Field positions
   localparam int          MODE_LSB     = 0;
   localparam int          CLOCK_SOURCE_DIRECTION_BIT    = 3;
   localparam int          SRC_LSB      = 0;
   localparam int          TX_SHIFT_EMPTY_FLAG_BIT    = 3;
   localparam int          NCH_BIT      = 5;
   localparam int          CLOCK_POLARITY_SEL_BIT    = 6;
   localparam int          BIT_ORDER_SEL_BIT    = 7;
   localparam int          TE_BIT       = 0;
   localparam int          TI_BIT       = 1;
   localparam int          RE_BIT       = 2;
   localparam int          RI_BIT       = 3;
   localparam int          IRS_BIT      = 0;
   localparam int          RRM_BIT      = 2;
   localparam int          OVR_BIT      = 0;
   // ==========================================================
   // Mode codes, prescaler and reset values
   localparam logic [2:0]  MODE_OFF     = 3'h0;
   localparam logic [2:0]  MODE_SYNC    = 3'h1;
   localparam logic [2:0]  PRE8_LAST    = 3'h7;
   localparam logic [4:0]  PRE32_LAST   = 5'h1f;
   typedef enum logic [1:0] {
      SRC_DIV1  = 2'h0,
      SRC_DIV8  = 2'h1,
      SRC_DIV32 = 2'h2
   } sscx_src_type;
   typedef enum logic {
      ST_IDLE  = 1'b0,
      ST_SHIFT = 1'b1
   } sscx_state_type;
endpackage

// ---- rtl/sscx_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sscx_sync
   import sscx_pkg::*;
#(
   parameter int W = 2
)(
   input  wire logic         clk,     // System clock
   input  wire logic         reset,   // Synchronous reset
   input  wire logic [W-1:0] async_in, // Pin levels
   output logic      [W-1:0] sync_out  // Synchronised levels
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sscx_sync_state_type;

   sscx_sync_state_type s;
   sscx_sync_state_type next_s;

   always_comb
   begin
      next_s.meta   = async_in;
      next_s.stable = s.meta;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         s <= '0;
      else
         s <= next_s;
   end

   assign sync_out = s.stable;
endmodule
`default_nettype wire

// ---- rtl/sscx_baud.sv ----
// Prescaler and baud divider: one tick per half transfer clock
`timescale 1ns/1ps
`default_nettype none
module sscx_baud
   import sscx_pkg::*;
(
   input  wire logic         clk,     // System clock
   input  wire logic         reset,   // Synchronous reset
   input  wire logic         run,     // Divider running
   input  wire sscx_src_type src_sel, // Prescaled source select
   input  wire logic [7:0]   divisor, // Divider value n
   output logic              tick     // Half-period pulse
);
   typedef struct packed {
      logic [4:0] pre;
      logic [7:0] cnt;
      logic       tick;
   } sscx_baud_state_type;

   sscx_baud_state_type s;
   sscx_baud_state_type next_s;
   logic                src_en;

   always_comb
   begin
      unique case (src_sel)
         SRC_DIV1:  src_en = 1'b1;
         SRC_DIV8:  src_en = (s.pre[2:0] == PRE8_LAST);
         SRC_DIV32: src_en = (s.pre == PRE32_LAST);
         default:   src_en = 1'b0;
      endcase
   end

   // n+1 source pulses per half period, so 2(n+1) per clock
   always_comb
   begin
      next_s      = s;
      next_s.pre  = s.pre + 5'h1;
      next_s.tick = 1'b0;
      if (!run)
         next_s.cnt = divisor;
      else if (src_en)
      begin
         if (s.cnt == 8'h0)
         begin
            next_s.cnt  = divisor;
            next_s.tick = 1'b1;
         end
         else
            next_s.cnt = s.cnt - 8'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         s <= '0;
      else
         s <= next_s;
   end

   assign tick = s.tick;
endmodule
`default_nettype wire

// ---- rtl/sscx_channel.sv ----
// Clock-synchronous serial channel with register port
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sscx_channel
   import sscx_pkg::*;
(
   input  wire logic              clk,                   // 25 MHz clock
   input  wire logic              reset,                 // Synchronous reset
   input  wire logic [ADDR_W-1:0] addr,                  // Register address
   input  wire logic [DATA_W-1:0] wdata,                 // Write data
   input  wire logic              wr,                    // Write strobe
   input  wire logic              rd,                    // Read strobe
   output logic      [DATA_W-1:0] rdata,                 // Read data, next cycle
   input  wire logic              serial_data_in,        // Data pin in
   output logic                   serial_data_out,       // Data pin out
   output logic                   serial_data_out_oe,    // Data pin enable
   input  wire logic              transfer_clock_pin_in, // Clock pin in
   output logic                   transfer_clock_pin_out, // Clock pin out
   output logic                   transfer_clock_pin_oe, // Clock pin enable
   output logic                   tx_irq_req,            // Transmit request pulse
   output logic                   rx_irq_req             // Receive request pulse
);
   typedef struct packed {
      logic [2:0]        mode;
      logic              clock_source_direction;
      sscx_src_type      src;
      logic              tx_shift_empty_flag;
      logic              open_drain_sel;
      logic              clock_polarity_sel;
      logic              bit_order_sel;
      logic              te;
      logic              ti;
      logic              re;
      logic              ri;
      logic              irs;
      logic              rrm;
      logic              ovr;
      logic [7:0]        baud;
      logic [7:0]        tx_buf;
      logic [7:0]        rx_buf;
      logic [7:0]        tx_sh;
      logic [7:0]        rx_sh;
      sscx_state_type    st;
      logic [3:0]        bits;
      logic              rx_on;
      logic              unread;
      logic              clk_lvl;
      logic              ext_prev;
      logic              dout;
      logic              pin_dout;
      logic              pin_doe;
      logic              pin_clk;
      logic              pin_coe;
      logic              tx_irq;
      logic              rx_irq;
      logic [DATA_W-1:0] rdata;
   } sscx_chan_state_type;

   sscx_chan_state_type s;
   sscx_chan_state_type next_s;
   logic [1:0]          pins_sync;
   logic                clk_sync;
   logic                din_sync;
   logic                tick;
   logic                mode_on;
   logic                edge_hit;
   logic                new_lvl;
   logic                launch;
   logic [7:0]          rx_shifted;

   // ==========================================================
   // Pin synchroniser and baud divider
   sscx_sync #(.W(2)) u_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in ({transfer_clock_pin_in, serial_data_in}),
      .sync_out (pins_sync)
   );

   sscx_baud u_baud (
      .clk     (clk),
      .reset   (reset),
      .run     (s.st == ST_SHIFT && !s.clock_source_direction),
      .src_sel (s.src),
      .divisor (s.baud),
      .tick    (tick)
   );

   assign clk_sync = pins_sync[1];
   assign din_sync = pins_sync[0];
   assign mode_on  = (s.mode == MODE_SYNC);
   assign new_lvl  = s.clock_source_direction ? clk_sync : !s.clk_lvl;
   assign edge_hit = (s.st == ST_SHIFT) && (s.clock_source_direction ? (clk_sync != s.ext_prev) : tick);
   assign launch   = (new_lvl == s.clock_polarity_sel);
   assign rx_shifted = s.bit_order_sel ? {s.rx_sh[6:0], din_sync}
                               : {din_sync, s.rx_sh[7:1]};

   // ==========================================================
   // Register port, transfer engine, pins
   always_comb
   begin
      next_s          = s;
      next_s.tx_irq   = 1'b0;
      next_s.rx_irq   = 1'b0;
      next_s.rdata    = '0;
      next_s.ext_prev = clk_sync;
      if (!mode_on || !s.re)
         next_s.ovr = 1'b0;
      if (!mode_on)
      begin
         next_s.st   = ST_IDLE;
         next_s.dout = 1'b1;
      end
      else if (s.st == ST_IDLE)
      begin
         if (s.te && !s.ti && (!s.clock_source_direction || clk_sync == !s.clock_polarity_sel))
         begin
            next_s.st     = ST_SHIFT;
            next_s.tx_sh  = s.tx_buf;
            next_s.ti     = 1'b1;
            next_s.tx_shift_empty_flag  = 1'b0;
            next_s.tx_irq = !s.irs;
            next_s.rx_on  = s.re;
            next_s.unread = s.ri;
            next_s.bits   = 4'h0;
         end
      end
      else if (edge_hit)
      begin
         next_s.clk_lvl = new_lvl;
         if (launch)
         begin
            next_s.dout  = s.bit_order_sel ? s.tx_sh[7] : s.tx_sh[0];
            next_s.tx_sh = s.bit_order_sel ? {s.tx_sh[6:0], 1'b0} : {1'b0, s.tx_sh[7:1]};
         end
         else
         begin
            next_s.rx_sh = rx_shifted;
            next_s.bits  = s.bits + 4'h1;
            if (s.bits == OVR_BIT_IDX && s.rx_on && s.unread)
               next_s.ovr = 1'b1;
            if (s.bits + 4'h1 == FRAME_BITS)
            begin
               next_s.st     = ST_IDLE;
               next_s.tx_shift_empty_flag  = 1'b1;
               next_s.tx_irq = s.irs;
               if (s.rx_on)
               begin
                  next_s.rx_buf = rx_shifted;
                  next_s.rx_irq = 1'b1;
               end
            end
         end
      end
      if (wr)
      begin
         unique case (addr)
            ADDR_DATA:
            begin
               next_s.tx_buf = wdata;
               next_s.ti     = 1'b0;
            end
            ADDR_BAUD:
               next_s.baud = wdata;
            ADDR_MODE:
            begin
               next_s.mode  = wdata[MODE_LSB +: 3];
               next_s.clock_source_direction = wdata[CLOCK_SOURCE_DIRECTION_BIT];
            end
            ADDR_CTRL0:
            begin
               next_s.src   = sscx_src_type'(wdata[SRC_LSB +: 2]);
               next_s.open_drain_sel   = wdata[NCH_BIT];
               next_s.clock_polarity_sel = wdata[CLOCK_POLARITY_SEL_BIT];
               next_s.bit_order_sel = wdata[BIT_ORDER_SEL_BIT];
            end
            ADDR_CTRL1:
            begin
               next_s.te = wdata[TE_BIT];
               next_s.re = wdata[RE_BIT];
            end
            ADDR_COMMON:
            begin
               next_s.irs = wdata[IRS_BIT];
               next_s.rrm = wdata[RRM_BIT];
            end
            default:
               next_s.baud = s.baud;
         endcase
      end
      if (rd)
      begin
         unique case (addr)
            ADDR_DATA:
            begin
               next_s.rdata  = s.rx_buf;
               next_s.unread = 1'b0;
               next_s.ri     = 1'b0;
               if (s.rrm && s.st == ST_IDLE)
                  next_s.ti = 1'b0;
            end
            ADDR_STATUS: next_s.rdata[OVR_BIT]   = s.ovr;
            ADDR_BAUD:   next_s.rdata            = s.baud;
            ADDR_MODE:
            begin
               next_s.rdata[MODE_LSB +: 3] = s.mode;
               next_s.rdata[CLOCK_SOURCE_DIRECTION_BIT]     = s.clock_source_direction;
            end
            ADDR_CTRL0:
            begin
               next_s.rdata[SRC_LSB +: 2] = s.src;
               next_s.rdata[TX_SHIFT_EMPTY_FLAG_BIT]    = s.tx_shift_empty_flag;
               next_s.rdata[NCH_BIT]      = s.open_drain_sel;
               next_s.rdata[CLOCK_POLARITY_SEL_BIT]    = s.clock_polarity_sel;
               next_s.rdata[BIT_ORDER_SEL_BIT]    = s.bit_order_sel;
            end
            ADDR_CTRL1:
            begin
               next_s.rdata[TE_BIT] = s.te;
               next_s.rdata[TI_BIT] = s.ti;
               next_s.rdata[RE_BIT] = s.re;
               next_s.rdata[RI_BIT] = s.ri;
            end
            ADDR_COMMON:
            begin
               next_s.rdata[IRS_BIT] = s.irs;
               next_s.rdata[RRM_BIT] = s.rrm;
            end
            default:     next_s.rdata = '0;
         endcase
      end
      // Landing beats a same-cycle buffer read
      if (next_s.rx_irq)
         next_s.ri = 1'b1;
      if (next_s.st == ST_IDLE)
         next_s.clk_lvl = !next_s.clock_polarity_sel;
      next_s.pin_clk  = next_s.clk_lvl;
      next_s.pin_coe  = (next_s.mode == MODE_SYNC) && !next_s.clock_source_direction;
      next_s.pin_dout = next_s.open_drain_sel ? 1'b0 : next_s.dout;
      next_s.pin_doe  = (next_s.mode == MODE_SYNC) && !(next_s.open_drain_sel && next_s.dout);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s       <= '0;
         s.ti    <= 1'b1;
         s.tx_shift_empty_flag <= 1'b1;
         s.dout  <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign rdata                  = s.rdata;
   assign serial_data_out        = s.pin_dout;
   assign serial_data_out_oe     = s.pin_doe;
   assign transfer_clock_pin_out = s.pin_clk;
   assign transfer_clock_pin_oe  = s.pin_coe;
   assign tx_irq_req             = s.tx_irq;
   assign rx_irq_req             = s.rx_irq;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_tx_start_cond: assert property ($rose(s.st == ST_SHIFT) |-> $past(s.te && !s.ti))
      else $error("transfer started without enable and data");
   a_frame_eight: assert property ($fell(s.st == ST_SHIFT) && mode_on |-> s.bits == FRAME_BITS)
      else $error("frame did not hold eight bits");
   a_tx_shift_empty_flag_shift: assert property ($rose(s.st == ST_SHIFT) |->
      !s.tx_shift_empty_flag && (s.ti || $past(wr && addr == ADDR_DATA)))
      else $error("shift empty flag not cleared at load");
   a_tx_irq_point: assert property ($rose(s.st == ST_SHIFT) |-> tx_irq_req == !$past(s.irs))
      else $error("transmit request at wrong point");
   a_rx_land: assert property (rx_irq_req |-> s.ri && s.rx_buf == $past(rx_shifted))
      else $error("receive request without landed frame");
   a_idle_clock: assert property (s.st == ST_IDLE && s.pin_coe |-> transfer_clock_pin_out == !s.clock_polarity_sel)
      else $error("idle clock at wrong level");
   a_clock_drive: assert property (mode_on |-> transfer_clock_pin_oe == !s.clock_source_direction)
      else $error("clock pin direction wrong");
   a_dout_idle: assert property ($rose(mode_on) && !s.open_drain_sel |-> serial_data_out && serial_data_out_oe)
      else $error("data output not high before transfer");
   a_overrun_set: assert property ($rose(s.ovr) |-> $past(s.bits) == OVR_BIT_IDX && $past(s.unread))
      else $error("overrun flagged at wrong bit");
   a_cont_rearm: assert property (rd && addr == ADDR_DATA && s.rrm && s.st == ST_IDLE && !wr |=> !s.ti || s.st == ST_SHIFT)
      else $error("buffer read did not rearm transfer");
endmodule
`default_nettype wire

// ---- tb/sscx_partner.sv ----
// Far-side serial peripheral model for the channel bench
`timescale 1ns/1ps
`default_nettype none
module sscx_partner (
   input  wire logic       sclk,      // Clock wire level
   input  wire logic       pol,       // Clock polarity
   input  wire logic       msb_first, // Bit order
   input  wire logic       mosi,      // Data from device
   input  wire logic [7:0] reply,     // Byte to return
   input  wire logic       ext_go,    // Start a clock burst
   input  wire logic       clr,       // Drop a partial frame
   output logic            miso,      // Data to device
   output logic            ext_clk,   // Clock when partner is master
   output logic      [7:0] got,       // Last byte taken in
   output int              frames     // Frames completed
);
   int   bits = 0;
   logic phase = 1'b0;
   logic armed = 1'b0;
   initial
   begin
      miso = 1'b1;
      got = 8'h00;
      frames = 0;
   end
   // ==========================================================
   // Clock burst, resting at idle level outside it
   assign ext_clk = ~pol ^ phase;
   always @(posedge ext_go) repeat (16) #230 phase = ~phase;
   always @(posedge clr)
   begin
      bits = 0;
      armed = 1'b0;
   end
   // ==========================================================
   // Launch toward polarity level, sample on the way back
   always @(sclk)
   begin
      if (sclk === pol)
      begin
         miso = reply[msb_first ? 7 - bits : bits];
         armed = 1'b1;
      end
      else if (armed)
      begin
         got[msb_first ? 7 - bits : bits] = mosi;
         armed = 1'b0;
         bits = bits + 1;
         if (bits == 8)
         begin
            bits = 0;
            frames = frames + 1;
            miso <= #200 ~miso; // Line toggled after hold time
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/sync_serial_channel_tb.sv ----
// Self-checking bench for the synchronous serial channel
`timescale 1ns/1ps
`default_nettype none
module sync_serial_channel_tb;
   import sscx_pkg::*;
   logic       clk, reset, wr, rd, sdo, sdo_oe, ckout, ckoe, txirq, rxirq;
   logic       miso, ext_clk, pol_r, msb_r, od, ext_m, ext_go, clr, last_ck;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, reply, rb, txb, got, rnd8;
   logic [31:0] rnd;
   wire logic  ck_wire;
   wire logic  sdo_wire;
   int         frames, mismatches, tests_run, cyc, tx_cyc, rx_cyc, rx_cnt;
   int         nedge, run, half_exp, f0, n0, cs;
   int         seed = 32'h4accc714;
   int         exp_q[$];
   int         pv[4] = '{1, 8, 32, 8};
   int         nv[4] = '{3, 0, 0, 1};
   int         sv[4] = '{0, 1, 2, 1};
   assign ck_wire = ckoe ? ckout : ext_clk;
   assign sdo_wire = sdo_oe ? sdo : 1'b1;
   sscx_channel DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .serial_data_in(miso), .serial_data_out(sdo),
      .serial_data_out_oe(sdo_oe), .transfer_clock_pin_in(ck_wire),
      .transfer_clock_pin_out(ckout), .transfer_clock_pin_oe(ckoe),
      .tx_irq_req(txirq), .rx_irq_req(rxirq));
   sscx_partner peer (.sclk(ck_wire), .pol(pol_r), .msb_first(msb_r), .mosi(sdo_wire),
      .reply(reply), .ext_go(ext_go), .clr(clr), .miso(miso), .ext_clk(ext_clk),
      .got(got), .frames(frames));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ==========================================================
   // Shared tasks
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task wait_frames(input int n);
      int k;
      k = 0;
      while (frames < n && k < 20000)
      begin
         @(posedge clk);
         k++;
      end
      check("frame finished", k < 20000, 1'b1);
      repeat (12) @(posedge clk);
   endtask
   task cfg(input logic [7:0] n, c0, cm, c1, md);
      wr_reg(ADDR_MODE, 8'h00);
      repeat (3) @(posedge clk);
      check("pins released", {ckoe, sdo_oe}, 2'b00);
      pol_r = c0[CLOCK_POLARITY_SEL_BIT];
      msb_r = c0[BIT_ORDER_SEL_BIT];
      od = c0[NCH_BIT];
      ext_m = md[CLOCK_SOURCE_DIRECTION_BIT];
      wr_reg(ADDR_BAUD, n);
      wr_reg(ADDR_CTRL0, c0);
      wr_reg(ADDR_COMMON, cm);
      wr_reg(ADDR_CTRL1, c1);
      wr_reg(ADDR_MODE, md);
      repeat (4) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      check("clock idle", {ckoe, ck_wire}, {~ext_m, ~pol_r});
      check("data idle", {sdo_oe, sdo_wire}, {~od, 1'b1});
   endtask
   task xfer;
      rnd = $random(seed);
      txb = rnd[7:0];
      reply = rnd[15:8];
      exp_q.push_back(reply);
      f0 = frames;
      n0 = rx_cnt;
      nedge = 0;
      cs = cyc;
      wr_reg(ADDR_DATA, txb);
      repeat (6) @(posedge clk);
      ext_go <= ext_m;
      rd_reg(ADDR_CTRL1, rb);
      check("buffer taken", rb[TI_BIT], 1'b1);
      rd_reg(ADDR_CTRL0, rb);
      check("shift busy", rb[TX_SHIFT_EMPTY_FLAG_BIT], 1'b0);
      ext_go <= 1'b0;
      wait_frames(f0 + 1);
      check("sent byte", got, txb);
      check("rx irq", rx_cnt, n0 + 1);
      rd_reg(ADDR_CTRL0, rb);
      check("shift done", rb[TX_SHIFT_EMPTY_FLAG_BIT], 1'b1);
      check("clock back idle", {ckoe, ck_wire}, {~ext_m, ~pol_r});
   endtask
   task rx_check;
      rd_reg(ADDR_CTRL1, rb);
      check("rx complete", rb[RI_BIT], 1'b1);
      rd_reg(ADDR_DATA, rb);
      check("rx byte", rb, exp_q.pop_front());
      rd_reg(ADDR_CTRL1, rb);
      check("rx read clears", rb[RI_BIT], 1'b0);
   endtask
   // ==========================================================
   // Reference timing: irq cycles and transfer clock half periods
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      run = run + 1;
      if (txirq === 1'b1)
         tx_cyc = cyc;
      if (rxirq === 1'b1)
      begin
         rx_cyc = cyc;
         rx_cnt++;
      end
      if (ckoe === 1'b1 && ckout !== last_ck)
      begin
         if (nedge > 0 && half_exp > 0)
            check("half period", run, half_exp);
         nedge++;
         run = 0;
      end
      last_ck = ckout;
   end
   initial
   begin
      #(40 * 60000);
      mismatches++;
      results;
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      {wr, rd, addr, wdata, ext_go, clr, pol_r, msb_r, od, ext_m} = '0;
      reply = 8'h00;
      reset = 1'b1;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rd_reg(ADDR_CTRL1, rb);
      check("empty at reset", rb[TI_BIT], 1'b1);
      rd_reg(ADDR_CTRL0, rb);
      check("shift empty at reset", rb[TX_SHIFT_EMPTY_FLAG_BIT], 1'b1);
      rd_reg(ADDR_MODE, rb);
      check("mode at reset", rb[2:0], MODE_OFF);
      rd_reg(3'h7, rb);
      check("unmapped read", rb, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         half_exp = (nv[i] + 1) * pv[i];
         cfg(nv[i][7:0], {i[1], i[0], 4'h0, sv[i][1:0]}, {7'h0, i[0]}, 8'h05, 8'h01);
         xfer;
         if (i[0])
            check("tx irq at end", (rx_cyc - tx_cyc) inside {[-3:3]}, 1'b1);
         else
            check("tx irq at load", tx_cyc > cs && rx_cyc - tx_cyc >= 15 * half_exp, 1'b1);
         rx_check;
      end
      half_exp = 4;
      cfg(8'h03, 8'h00, 8'h00, 8'h00, 8'h01);
      f0 = frames;
      n0 = rx_cnt;
      rnd = $random(seed);
      rnd8 = rnd[7:0];
      wr_reg(ADDR_DATA, rnd8);
      repeat (200) @(posedge clk);
      check("held without enable", frames, f0);
      rd_reg(ADDR_CTRL1, rb);
      check("buffer still full", rb[TI_BIT], 1'b0);
      nedge = 0;
      wr_reg(ADDR_CTRL1, 8'h01);
      wait_frames(f0 + 1);
      check("transmit only byte", got, rnd8);
      rd_reg(ADDR_CTRL1, rb);
      check("no reception", {rb[RI_BIT], rx_cnt == n0}, 2'b01);
      cfg(8'h03, 8'h00, 8'h00, 8'h05, 8'h01);
      xfer;
      rd_reg(ADDR_STATUS, rb);
      check("no overrun yet", rb[OVR_BIT], 1'b0);
      xfer;
      rd_reg(ADDR_STATUS, rb);
      check("overrun flag", rb[OVR_BIT], 1'b1);
      exp_q.delete();
      rd_reg(ADDR_DATA, rb);
      cfg(8'h03, 8'h00, 8'h00, 8'h05, 8'h01);
      xfer;
      wr_reg(ADDR_COMMON, 8'h04);
      f0 = frames;
      rnd = $random(seed);
      reply = rnd[7:0];
      nedge = 0;
      rx_check;
      exp_q.push_back(reply);
      wait_frames(f0 + 1);
      check("dummy repeated", got, txb);
      wr_reg(ADDR_COMMON, 8'h00);
      rx_check;
      half_exp = 0;
      cfg(8'h00, 8'h60, 8'h00, 8'h05, 8'h09);
      xfer;
      rx_check;
      wr_reg(ADDR_MODE, 8'h00);
      results;
   end
endmodule
`default_nettype wire
